// [hw/handler_pkg.sv]
/*
  Shared constants and types of the handler handshake block.
  Assumes a 200 MHz pclk; times below are typical figures in ns.
*/
`default_nettype none
package handler_pkg;
  // register byte offsets
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] DRIVE_OFS = 8'h04;
  localparam logic [7:0] RESULT_OFS = 8'h08;
  localparam logic [7:0] TEST_OFS = 8'h0c;
  localparam logic [7:0] STATUS_OFS = 8'h10;
  localparam logic [7:0] IRQ_STAT_OFS = 8'h14;
  localparam logic [7:0] IRQ_MASK_OFS = 8'h18;
  // control fields
  localparam int CTRL_TEST_BIT = 0;
  localparam int CTRL_FREQ_LSB = 1;
  localparam int FREQ_W = 2;
  localparam logic [1:0] FREQ_LOW = 2'h0;
  localparam logic [1:0] FREQ_MID = 2'h1;
  localparam logic [1:0] CTRL_RST = 2'h0;
  // drive voltage in whole volts
  localparam int DRIVE_W = 5;
  localparam logic [4:0] DRIVE_RST = 5'h05;
  localparam logic [4:0] THR_MID_V = 5'h09;
  localparam logic [4:0] THR_HIGH_V = 5'h0f;
  // timing
  localparam int CLK_NS = 5;
  localparam int RESP_NS = 40000;
  localparam int MEAS_LOW_NS = 10000000;
  localparam int MEAS_MID_NS = 2000000;
  localparam int MEAS_HIGH_NS = 1300000;
  localparam int COMP_NS = 1000000;
  localparam int RESP_CYC = RESP_NS / CLK_NS;
  localparam int MEAS_LOW_CYC = MEAS_LOW_NS / CLK_NS;
  localparam int MEAS_MID_CYC = MEAS_MID_NS / CLK_NS;
  localparam int MEAS_HIGH_CYC = MEAS_HIGH_NS / CLK_NS;
  localparam int COMP_CYC = COMP_NS / CLK_NS;
  localparam int CNT_W = 22;
  // bin lines: bins 1..9, aux, out of bins
  localparam int NBIN = 11;
  localparam int BIN_W = 4;
  // event and status bit positions
  localparam int EV_TRIG = 0;
  localparam int EV_ANALOG = 1;
  localparam int EV_CYCLE = 2;
  localparam int EV_MISS = 3;
  localparam int EV_W = 4;
  localparam int ST_TRIG_LVL = 0;
  localparam int ST_LOCK_LVL = 1;
  localparam int ST_BUSY = 2;
  localparam int ST_MEAS = 3;
  localparam int ST_COMP = 4;
  localparam int ST_THR_LSB = 5;

  typedef struct packed {
    logic fault;
    logic overrange;
    logic low_cap;
    logic secondary;
    logic lower;
    logic upper;
    logic [3:0] bin;
  } res_t;

  typedef struct packed {
    logic ready;
    logic analog_done;
    logic cycle_done;
    res_t res;
  } lines_t;

  localparam logic [9:0] RESULT_RST = 10'h000;
  localparam logic [12:0] LINES_RST = 13'h1ff0;
  localparam logic [12:0] NORM_RST = 13'h0ff0;

  typedef enum logic [1:0] {S_READY, S_RESPOND, S_MEASURE, S_COMPUTE} seq_state_t;
endpackage : handler_pkg
`default_nettype wire

// [hw/level_sync.sv]
/*
  Two-flop synchroniser with rising-edge detect, one per bit.
  Assumes inputs may change at any time relative to pclk.
*/
`default_nettype none
module level_sync #(
  parameter int WIDTH = 2
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // raw and synchronised levels
  input wire logic [WIDTH-1:0] raw_in,
  output logic [WIDTH-1:0] level,
  output logic [WIDTH-1:0] rise
);
  logic [WIDTH-1:0] meta_reg, sync_reg, prev_reg;

  // first stage feeds only the second
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_reg <= '0;
      sync_reg <= '0;
      prev_reg <= '0;
    end else begin
      meta_reg <= raw_in;
      sync_reg <= meta_reg;
      prev_reg <= sync_reg;
    end
  end

  always_comb begin
    level = sync_reg;
    rise = sync_reg & ~prev_reg;
  end
endmodule : level_sync
`default_nettype wire

// [hw/handler_handshake.sv]
/*
  Handler handshake sequencer, threshold select and maintenance test mode,
  with an APB register slave and one level interrupt.
  Assumes a single 200 MHz pclk; handler lines are async and synchronised here.
*/
`default_nettype none
//
// Contract
// - ready, analog-done and cycle-done change 40 us after a trigger.
// - measure 10.0/2.0/1.3 ms by frequency, then 1.0 ms compute.
// - judgment lines invalid during compute; handler waits for cycle-done.
// - exactly one threshold switch closed, chosen from drive voltage bands.
// - test mode detaches the lines from measurement results.
// - test mode sets the bin line pattern directly; code takes a 4-bit bin code and drives at most one line low.
// - test mode sets upper, lower and secondary limit flags directly.
// - test mode forces each status line high or low.
// - trigger and lockout input levels are readable.
// - leaving test mode returns lines to measurement results.
// - ready low when a trigger can be taken; handler triggers only then.
// - analog-done low when analog measurement ends.
// - cycle-done low only when sequence finished and judgment valid.
module handler_handshake
  import handler_pkg::*;
#(
  parameter int RESP_CYCLES = RESP_CYC,
  parameter int MEAS_LOW_CYCLES = MEAS_LOW_CYC,
  parameter int MEAS_MID_CYCLES = MEAS_MID_CYC,
  parameter int MEAS_HIGH_CYCLES = MEAS_HIGH_CYC,
  parameter int COMP_CYCLES = COMP_CYC
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // handler inputs
  input wire logic external_trigger_in,
  input wire logic panel_lockout_n,
  // handler operation outputs
  output logic trigger_accept_ready_n,
  output logic analog_done_n,
  output logic cycle_done_n,
  output logic fault_n,
  // handler judgment outputs
  output logic overrange_n,
  output logic low_cap_or_open_n,
  output logic upper_limit_fail_n,
  output logic lower_limit_fail_n,
  output logic secondary_reject_n,
  output logic [NBIN-1:0] bin_n,
  // input threshold switches
  output logic threshold_sel_low,
  output logic threshold_sel_mid,
  output logic threshold_sel_high,
  // interrupt
  output logic irq
);
  function automatic logic [NBIN-1:0] bin_lines_n(input logic [BIN_W-1:0] code);
    logic [NBIN-1:0] v;
    v = '1;
    for (int i = 0; i < NBIN; i++) begin
      if (code == BIN_W'(i + 1)) v[i] = 1'b0;
    end
    return v;
  endfunction : bin_lines_n

  logic [1:0] in_level, in_rise;
  logic trig_rise;

  level_sync #(.WIDTH(2)) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .raw_in({panel_lockout_n, external_trigger_in}),
    .level(in_level),
    .rise(in_rise)
  );
  assign trig_rise = in_rise[0];

  // registers
  logic test_mode_reg, test_mode_next;
  logic [FREQ_W-1:0] freq_reg, freq_next;
  logic [DRIVE_W-1:0] drive_reg, drive_next;
  res_t result_reg, result_next;
  lines_t test_reg, test_next;
  logic [EV_W-1:0] stat_reg, stat_next, mask_reg, mask_next, ev;
  logic irq_reg, irq_next;
  logic [31:0] prdata_reg, prdata_next;
  logic pready_reg, pready_next, pslverr_reg, pslverr_next;
  // sequencer
  seq_state_t state_reg, state_next;
  logic [CNT_W-1:0] cnt_reg, cnt_next, meas_len_reg, meas_len_next, age_reg, age_next;
  lines_t norm_reg, norm_next, pin_reg, pin_next;
  logic [NBIN-1:0] bin_reg, bin_next;
  logic [2:0] thr_reg, thr_next;

  logic access, done;
  assign access = psel & penable;
  assign done = access & pready_reg;

  always_comb begin
    test_mode_next = test_mode_reg;
    freq_next = freq_reg;
    drive_next = drive_reg;
    result_next = result_reg;
    test_next = test_reg;
    mask_next = mask_reg;
    stat_next = stat_reg;
    prdata_next = prdata_reg;
    pslverr_next = pslverr_reg;
    // one wait state so read data comes from a flop
    pready_next = access & ~pready_reg;
    if (access && !pready_reg) begin
      prdata_next = '0;
      pslverr_next = 1'b0;
      if (paddr == CTRL_OFS) begin
        prdata_next[FREQ_W+CTRL_FREQ_LSB-1:0] = {freq_reg, test_mode_reg};
      end else if (paddr == DRIVE_OFS) begin
        prdata_next[DRIVE_W-1:0] = drive_reg;
      end else if (paddr == RESULT_OFS) begin
        prdata_next[$bits(res_t)-1:0] = result_reg;
      end else if (paddr == TEST_OFS) begin
        prdata_next[$bits(lines_t)-1:0] = test_reg;
      end else if (paddr == STATUS_OFS) begin
        prdata_next[ST_TRIG_LVL] = in_level[0];
        prdata_next[ST_LOCK_LVL] = in_level[1];
        prdata_next[ST_BUSY] = state_reg != S_READY;
        prdata_next[ST_MEAS] = state_reg == S_MEASURE;
        prdata_next[ST_COMP] = state_reg == S_COMPUTE;
        prdata_next[ST_THR_LSB+2:ST_THR_LSB] = thr_reg;
      end else if (paddr == IRQ_STAT_OFS) begin
        prdata_next[EV_W-1:0] = stat_reg;
      end else if (paddr == IRQ_MASK_OFS) begin
        prdata_next[EV_W-1:0] = mask_reg;
      end else begin
        pslverr_next = 1'b1;
      end
    end
    if (done && pwrite) begin
      if (paddr == CTRL_OFS) begin
        test_mode_next = pwdata[CTRL_TEST_BIT];
        freq_next = pwdata[CTRL_FREQ_LSB+FREQ_W-1:CTRL_FREQ_LSB];
      end else if (paddr == DRIVE_OFS) begin
        drive_next = pwdata[DRIVE_W-1:0];
      end else if (paddr == RESULT_OFS) begin
        result_next = pwdata[$bits(res_t)-1:0];
      end else if (paddr == TEST_OFS) begin
        test_next = pwdata[$bits(lines_t)-1:0];
      end else if (paddr == IRQ_MASK_OFS) begin
        mask_next = pwdata[EV_W-1:0];
      end
    end
    // clear only what was reported; a new event still sets
    if (done && !pwrite && paddr == IRQ_STAT_OFS) stat_next = stat_reg & ~prdata_reg[EV_W-1:0];
    stat_next = stat_next | ev;
    irq_next = |(stat_next & mask_next);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {freq_reg, test_mode_reg} <= {CTRL_RST, 1'b0};
      drive_reg <= DRIVE_RST;
      result_reg <= RESULT_RST;
      test_reg <= LINES_RST;
      mask_reg <= '0;
      stat_reg <= '0;
      irq_reg <= 1'b0;
      prdata_reg <= '0;
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
    end else begin
      test_mode_reg <= test_mode_next;
      freq_reg <= freq_next;
      drive_reg <= drive_next;
      result_reg <= result_next;
      test_reg <= test_next;
      mask_reg <= mask_next;
      stat_reg <= stat_next;
      irq_reg <= irq_next;
      prdata_reg <= prdata_next;
      pready_reg <= pready_next;
      pslverr_reg <= pslverr_next;
    end
  end

  // sequencer; normal-mode line levels kept in norm_reg
  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    meas_len_next = meas_len_reg;
    age_next = age_reg + 1'b1;
    norm_next = norm_reg;
    norm_next.res.fault = ~result_reg.fault;
    ev = '0;
    if (test_mode_reg) begin
      state_next = S_READY;
      cnt_next = '0;
    end else begin
      if (trig_rise && state_reg != S_READY) ev[EV_MISS] = 1'b1;
      case (state_reg)
        S_READY: begin
          if (trig_rise) begin
            state_next = S_RESPOND;
            cnt_next = CNT_W'(RESP_CYCLES - 1);
            ev[EV_TRIG] = 1'b1;
            if (freq_reg == FREQ_LOW) meas_len_next = CNT_W'(MEAS_LOW_CYCLES - 1);
            else if (freq_reg == FREQ_MID) meas_len_next = CNT_W'(MEAS_MID_CYCLES - 1);
            else meas_len_next = CNT_W'(MEAS_HIGH_CYCLES - 1);
          end
        end
        S_RESPOND: begin
          if (cnt_reg == '0) begin
            state_next = S_MEASURE;
            cnt_next = meas_len_reg;
            norm_next.ready = 1'b1;
            norm_next.analog_done = 1'b1;
            norm_next.cycle_done = 1'b1;
          end else cnt_next = cnt_reg - 1'b1;
        end
        S_MEASURE: begin
          if (cnt_reg == '0) begin
            state_next = S_COMPUTE;
            cnt_next = CNT_W'(COMP_CYCLES - 1);
            norm_next.analog_done = 1'b0;
            // judgment lines held inactive while invalid
            norm_next.res = '1;
            norm_next.res.bin = '0;
            norm_next.res.fault = ~result_reg.fault;
            ev[EV_ANALOG] = 1'b1;
          end else cnt_next = cnt_reg - 1'b1;
        end
        S_COMPUTE: begin
          if (cnt_reg == '0) begin
            state_next = S_READY;
            norm_next.res = ~result_reg;
            norm_next.res.bin = result_reg.bin;
            norm_next.cycle_done = 1'b0;
            norm_next.ready = 1'b0;
            ev[EV_CYCLE] = 1'b1;
          end else cnt_next = cnt_reg - 1'b1;
        end
        default: state_next = S_READY;
      endcase
    end
    if (state_next != state_reg) age_next = '0;
    // test mode drives the pins from the test register, else results
    pin_next = test_mode_reg ? test_reg : norm_reg;
    bin_next = bin_lines_n(pin_next.res.bin);
    if (drive_reg < THR_MID_V) thr_next = 3'h1;
    else if (drive_reg < THR_HIGH_V) thr_next = 3'h2;
    else thr_next = 3'h4;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= S_READY;
      cnt_reg <= '0;
      meas_len_reg <= '0;
      age_reg <= '0;
      norm_reg <= NORM_RST;
      pin_reg <= NORM_RST;
      bin_reg <= '1;
      thr_reg <= 3'h1;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      meas_len_reg <= meas_len_next;
      age_reg <= age_next;
      norm_reg <= norm_next;
      pin_reg <= pin_next;
      bin_reg <= bin_next;
      thr_reg <= thr_next;
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign irq = irq_reg;
  assign trigger_accept_ready_n = pin_reg.ready;
  assign analog_done_n = pin_reg.analog_done;
  assign cycle_done_n = pin_reg.cycle_done;
  assign fault_n = pin_reg.res.fault;
  assign overrange_n = pin_reg.res.overrange;
  assign low_cap_or_open_n = pin_reg.res.low_cap;
  assign upper_limit_fail_n = pin_reg.res.upper;
  assign lower_limit_fail_n = pin_reg.res.lower;
  assign secondary_reject_n = pin_reg.res.secondary;
  assign bin_n = bin_reg;
  assign {threshold_sel_high, threshold_sel_mid, threshold_sel_low} = thr_reg;

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence meas_end;
    state_reg == S_MEASURE && state_next == S_COMPUTE;
  endsequence
  sequence cycle_end;
    state_reg == S_COMPUTE && state_next == S_READY;
  endsequence

  trig_start_a: assert property (
    state_reg == S_READY && trig_rise && !test_mode_reg |=> state_reg == S_RESPOND)
    else $error("accepted trigger did not start a cycle");
  single_edge_a: assert property (trig_rise |=> !trig_rise)
    else $error("one trigger gave two edges");
  resp_time_a: assert property (
    state_reg == S_RESPOND && state_next == S_MEASURE
      |-> age_reg == CNT_W'(RESP_CYCLES - 1) ##1 norm_reg.ready && norm_reg.cycle_done)
    else $error("response latency wrong");
  meas_time_a: assert property (meas_end |-> age_reg == meas_len_reg)
    else $error("analog phase length wrong");
  comp_time_a: assert property (
    cycle_end |-> age_reg == CNT_W'(COMP_CYCLES - 1))
    else $error("compute phase length wrong");
  hidden_data_a: assert property (
    state_reg == S_COMPUTE |-> norm_reg.cycle_done && norm_reg.res.upper
      && norm_reg.res.bin == '0)
    else $error("judgment shown before cycle end");
  thr_pick_a: assert property (
    drive_reg >= THR_HIGH_V |=> threshold_sel_high && !threshold_sel_low && !threshold_sel_mid)
    else $error("wrong threshold switch");
  test_lines_a: assert property (
    test_mode_reg |=> {trigger_accept_ready_n, analog_done_n, cycle_done_n, fault_n,
      overrange_n, low_cap_or_open_n} == $past({test_reg.ready, test_reg.analog_done,
      test_reg.cycle_done, test_reg.res.fault, test_reg.res.overrange, test_reg.res.low_cap}))
    else $error("status line not forced in test mode");
  test_bin_a: assert property (
    test_mode_reg |=> bin_n == bin_lines_n($past(test_reg.res.bin))
      && upper_limit_fail_n == $past(test_reg.res.upper))
    else $error("bin or limit line not forced in test mode");
  resume_a: assert property (
    !test_mode_reg |=> cycle_done_n == $past(norm_reg.cycle_done)
      && secondary_reject_n == $past(norm_reg.res.secondary))
    else $error("lines not from results outside test mode");
  analog_end_a: assert property (meas_end |=> !norm_reg.analog_done && norm_reg.cycle_done)
    else $error("analog-done not shown at analog end");
  cycle_end_a: assert property (
    cycle_end |=> !norm_reg.cycle_done && !norm_reg.ready
      && norm_reg.res.upper == !$past(result_reg.upper))
    else $error("cycle-done without valid judgment");
endmodule : handler_handshake
`default_nettype wire

// [verification/handler_model.sv]
/*
  Handler-side model: raises the trigger, holds the lockout line and
  captures the bin lines once the device reports the cycle is over.
  Assumes pclk from the bench; lines change just after a rising edge.
*/
`default_nettype none
module handler_model #(
  parameter int WAIT_MAX = 5000
) (
  // clock
  input wire logic pclk,
  // lines into the device
  output var logic external_trigger_in,
  output var logic panel_lockout_n,
  // lines from the device
  input wire logic trigger_accept_ready_n,
  input wire logic cycle_done_n,
  input wire logic [10:0] bin_n
);
  timeunit 1ns;
  timeprecision 100ps;
  logic done_q;
  logic [10:0] seen_bin;
  initial begin
    external_trigger_in = 1'b0;
    panel_lockout_n = 1'b1;
    done_q = 1'b1;
    seen_bin = 11'h7ff;
  end
  // judgment is garbage while computing, so only look at the done edge
  always @(posedge pclk) begin
    done_q <= cycle_done_n;
    if (!cycle_done_n && done_q) seen_bin <= bin_n;
  end
  task automatic pulse(input int width);
    @(posedge pclk);
    external_trigger_in <= 1'b1;
    repeat (width) @(posedge pclk);
    external_trigger_in <= 1'b0;
  endtask : pulse
  task automatic fire(input int width);
    int n;
    n = 0;
    while (trigger_accept_ready_n !== 1'b0 && n < WAIT_MAX) begin
      @(posedge pclk);
      n++;
    end
    pulse(width);
  endtask : fire
  task automatic drive(input logic t, input logic k);
    @(posedge pclk);
    external_trigger_in <= t;
    panel_lockout_n <= k;
  endtask : drive
endmodule : handler_model
`default_nettype wire

// [verification/handler_handshake_test.sv]
/*
  Self-checking bench of the handler handshake block with an APB master.
  Assumes shortened phase counts; the handler model drives the trigger.
*/
`default_nettype none
module handler_handshake_test
  import handler_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int RESP = 8;
  localparam int ML = 500;
  localparam int MM = 300;
  localparam int MH = 260;
  localparam int COMP = 50;
  localparam logic [4:0] VT [6] = '{5'h05, 5'h08, 5'h09, 5'h0e, 5'h0f, 5'h18};
  localparam logic [2:0] VS [6] = '{3'h1, 3'h1, 3'h2, 3'h2, 3'h4, 3'h4};
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  wire logic external_trigger_in, panel_lockout_n;
  logic trigger_accept_ready_n, analog_done_n, cycle_done_n, fault_n;
  logic overrange_n, low_cap_or_open_n, upper_limit_fail_n, lower_limit_fail_n;
  logic secondary_reject_n, threshold_sel_low, threshold_sel_mid, threshold_sel_high;
  logic [NBIN-1:0] bin_n;
  logic [9:0] last_r;
  int error_cnt, num_checks, cyc;

  handler_handshake #(.RESP_CYCLES(RESP), .MEAS_LOW_CYCLES(ML), .MEAS_MID_CYCLES(MM),
    .MEAS_HIGH_CYCLES(MH), .COMP_CYCLES(COMP)) handler_handshake_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .external_trigger_in(external_trigger_in), .panel_lockout_n(panel_lockout_n),
    .trigger_accept_ready_n(trigger_accept_ready_n), .analog_done_n(analog_done_n),
    .cycle_done_n(cycle_done_n), .fault_n(fault_n), .overrange_n(overrange_n),
    .low_cap_or_open_n(low_cap_or_open_n), .upper_limit_fail_n(upper_limit_fail_n),
    .lower_limit_fail_n(lower_limit_fail_n), .secondary_reject_n(secondary_reject_n),
    .bin_n(bin_n), .threshold_sel_low(threshold_sel_low),
    .threshold_sel_mid(threshold_sel_mid), .threshold_sel_high(threshold_sel_high),
    .irq(irq));
  handler_model handler_model_inst (.pclk(pclk), .external_trigger_in(external_trigger_in),
    .panel_lockout_n(panel_lockout_n), .trigger_accept_ready_n(trigger_accept_ready_n),
    .cycle_done_n(cycle_done_n), .bin_n(bin_n));

  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  always @(posedge pclk) cyc++;

  task automatic complete_run();
    if (error_cnt == 0 && num_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : complete_run
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  function automatic logic [8:0] pins();
    return {trigger_accept_ready_n, analog_done_n, cycle_done_n, fault_n, overrange_n,
      low_cap_or_open_n, secondary_reject_n, lower_limit_fail_n, upper_limit_fail_n};
  endfunction : pins
  function automatic logic [10:0] exp_bin(input logic [3:0] c);
    exp_bin = 11'h7ff;
    if (c >= 4'h1 && c <= 4'hb) exp_bin[c - 4'h1] = 1'b0;
  endfunction : exp_bin
  function automatic logic sig(input int s);
    case (s)
      0: return trigger_accept_ready_n;
      1: return analog_done_n;
      2: return cycle_done_n;
      default: return external_trigger_in;
    endcase
  endfunction : sig
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] q, output logic e);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) chk(32'h0, 32'h1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
    chk(32'(e), 32'(a > 8'h18));
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] m);
    logic [31:0] q;
    logic e;
    apb(1'b0, a, 32'h0, q, e);
    chk(32'(e), 32'(a > 8'h18));
    chk(q & m, exp);
  endtask : rd
  // bounded wait for a handshake line, sampled mid-cycle
  task automatic wait_sig(input int s, input logic v, output int t);
    int n;
    n = 0;
    @(negedge pclk);
    while (sig(s) !== v && n < 2000) begin
      @(negedge pclk);
      n++;
    end
    if (n >= 2000) chk(32'h0, 32'h1);
    t = cyc;
  endtask : wait_sig

  task automatic reset_values();
    chk(32'(pins()), 32'h0ff);
    chk(32'({threshold_sel_high, threshold_sel_mid, threshold_sel_low}), 32'h1);
    rd(CTRL_OFS, 32'h0, 32'hffffffff);
    rd(DRIVE_OFS, 32'h5, 32'hffffffff);
    rd(RESULT_OFS, 32'h0, 32'hffffffff);
    rd(TEST_OFS, 32'h1ff0, 32'hffffffff);
    rd(IRQ_MASK_OFS, 32'h0, 32'hffffffff);
    rd(IRQ_STAT_OFS, 32'h0, 32'hffffffff);
    rd(8'h1c, 32'h0, 32'hffffffff);
    wr(8'h1c, 32'hffffffff);
  endtask : reset_values
  task automatic thresholds();
    for (int i = 0; i < 6; i++) begin
      wr(DRIVE_OFS, 32'(VT[i]));
      repeat (3) @(negedge pclk);
      chk(32'({threshold_sel_high, threshold_sel_mid, threshold_sel_low}), 32'(VS[i]));
      rd(STATUS_OFS, 32'({VS[i], 5'h00}), 32'he0);
    end
  endtask : thresholds
  task automatic run_cycle(input logic [1:0] f, input int m, input logic [3:0] mask,
      input logic [9:0] r);
    int t0, t1, t2, t3;
    last_r = r;
    wr(CTRL_OFS, {29'h0, f, 1'b0});
    wr(RESULT_OFS, 32'(r));
    wr(IRQ_MASK_OFS, 32'(mask));
    fork
      handler_model_inst.fire(200);
    join_none
    wait_sig(3, 1'b1, t0);
    wait_sig(0, 1'b1, t1);
    chk(32'(t1 - t0 >= RESP && t1 - t0 <= RESP + 8), 32'h1);
    chk(32'(pins() >> 6), 32'h7);
    wait_sig(1, 1'b0, t2);
    chk(32'(t2 - t1), 32'(m));
    chk(32'({5'(pins()), bin_n}), 32'hffff);
    wait_sig(2, 1'b0, t3);
    chk(32'(t3 - t2), 32'(COMP));
    chk(32'(pins()), 32'({3'h0, ~r[9:4]}));
    chk(32'(bin_n), 32'(exp_bin(r[3:0])));
    repeat (2) @(negedge pclk);
    chk(32'(handler_model_inst.seen_bin), 32'(exp_bin(r[3:0])));
    chk(32'(irq), 32'(mask != 4'h0));
    rd(IRQ_STAT_OFS, 32'h7, 32'hffffffff);
    // irq drops at the completing edge, so look once it has settled
    @(negedge pclk);
    chk(32'(irq), 32'h0);
  endtask : run_cycle
  // a second pulse while busy must be dropped and flagged
  task automatic missed();
    int t;
    wr(CTRL_OFS, 32'h6);
    wr(IRQ_MASK_OFS, 32'h8);
    fork
      begin
        handler_model_inst.fire(200);
        repeat (20) @(posedge pclk);
        handler_model_inst.pulse(200);
      end
    join_none
    wait_sig(2, 1'b1, t);
    wait_sig(2, 1'b0, t);
    repeat (300) @(negedge pclk);
    chk(32'(pins() >> 6), 32'h0);
    chk(32'(irq), 32'h1);
    rd(IRQ_STAT_OFS, 32'hf, 32'hffffffff);
  endtask : missed
  task automatic test_mode();
    logic [12:0] v;
    wr(CTRL_OFS, 32'h1);
    repeat (3) @(negedge pclk);
    chk(32'({pins(), bin_n}), 32'hfffff);
    for (int k = 0; k < 12; k++) begin
      v = 13'h1ff0 | 13'(k);
      if (k < 9) v[k + 4] = 1'b0;
      wr(TEST_OFS, 32'(v));
      repeat (3) @(negedge pclk);
      chk(32'(pins()), 32'(v[12:4]));
      chk(32'(bin_n), 32'(exp_bin(v[3:0])));
    end
    handler_model_inst.drive(1'b1, 1'b0);
    repeat (6) @(negedge pclk);
    rd(STATUS_OFS, 32'h1, 32'h3);
    handler_model_inst.drive(1'b0, 1'b1);
    repeat (6) @(negedge pclk);
    rd(STATUS_OFS, 32'h2, 32'h3);
    rd(IRQ_STAT_OFS, 32'h0, 32'hffffffff);
    wr(CTRL_OFS, 32'h0);
    repeat (3) @(negedge pclk);
    chk(32'(pins()), 32'({3'h0, ~last_r[9:4]}));
    chk(32'(bin_n), 32'(exp_bin(last_r[3:0])));
  endtask : test_mode

  initial begin
    #500000;
    error_cnt++;
    complete_run();
  end
  initial begin
    error_cnt = 0;
    num_checks = 0;
    cyc = 0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    reset_values();
    thresholds();
    run_cycle(FREQ_LOW, ML, 4'h0, 10'h013);
    run_cycle(FREQ_MID, MM, 4'h7, 10'h0a9);
    run_cycle(2'h2, MH, 4'h4, 10'h34b);
    missed();
    test_mode();
    complete_run();
  end
endmodule : handler_handshake_test
`default_nettype wire
